// [verilog/scs_pkg.sv]
// Constants, register map and types for the SAR converter sequencer.
// Assumes a 100 MHz system clock and an 8-bit register port.
//
// Contract
// [RULE1] Each conversion yields a 10-bit unsigned result for the chosen channel.
// [RULE2] An eight-input multiplexer is addressed by the 3-bit channel_select field.
// [RULE3] channel_select is a binary index, 000 picks input zero, 111 input seven.
// [RULE4] A finished conversion writes its result into the readable data registers.
// [RULE5] Phases run in order: sampling, then settling, then conversion.
// [RULE6] The conversion phase lasts exactly 13 conversion_clock cycles.
// [RULE7] conversion_clock is the system clock divided by a fixed 16.
// [RULE8] Sampling lasts a programmed cycle count; software keeps it at least 1.0 us.
// [RULE9] Settling lasts a programmed cycle count; software keeps it at least 0.5 us.
// [RULE10] Writing 1 to control bit 7 starts a conversion on the selected channel.
// [RULE11] A start during a conversion aborts it and restarts from sampling.
// [RULE12] Start bit reads 1 while busy; software polls it before restarting.
// [RULE13] Completion of a conversion raises an interrupt request.
// [RULE14] Disabling the converter leaves a pending completion request asserted.
// [RULE15] Control bit 5 enables the reference buffer; cleared selects external reference.
// [RULE16] Below ground reads zeros, above reference all ones, else 1024*in/ref.
// [RULE17] Software writes zero to reserved control bits 6 and 3.
// [RULE18] Start bit clears when conversion ends, with result store and interrupt.
// [RULE19] A sequence starts or continues only while converter_enable, bit 4, is set.

package scs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SCS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SCS_ADDR_DATA_HI = 8'h01;
    localparam logic [7:0] SCS_ADDR_DATA_LO = 8'h02;
    localparam logic [7:0] SCS_ADDR_SAMPLE = 8'h03;
    localparam logic [7:0] SCS_ADDR_SETTLE = 8'h04;
    localparam logic [7:0] SCS_ADDR_STATUS = 8'h05;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int SCS_RES_W = 10;
    localparam logic [7:0] SCS_CTRL_RESET = 8'h00;
    localparam logic [9:0] SCS_RES_MSB = 10'h200;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SCS_CLK_PERIOD_NS = 10;
    localparam int SCS_SAMPLE_MIN_NS = 1000;
    localparam int SCS_SETTLE_MIN_NS = 500;
    localparam int SCS_SAMPLE_MIN_CYC =
        (SCS_SAMPLE_MIN_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;
    localparam int SCS_SETTLE_MIN_CYC =
        (SCS_SETTLE_MIN_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;
    localparam logic [7:0] SCS_SAMPLE_RESET = 8'(SCS_SAMPLE_MIN_CYC);
    localparam logic [7:0] SCS_SETTLE_RESET = 8'(SCS_SETTLE_MIN_CYC);
    localparam logic [3:0] SCS_DIV_LAST = 4'hF;
    localparam logic [3:0] SCS_CONV_TICKS_LAST = 4'hC;
    localparam logic [3:0] SCS_SAR_TICKS = 4'hA;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic rsvd6;
        logic reference_select;
        logic converter_enable;
        logic rsvd3;
        logic [2:0] channel_select;
    } scs_ctrl_t;

    typedef struct packed {
        logic [2:0] channel_select;
        logic reference_buffer_en;
        logic sample;
        logic hold;
        logic [9:0] dac_code;
    } scs_analog_t;

    typedef enum logic [1:0] {
        SCS_IDLE,
        SCS_SAMPLE,
        SCS_SETTLE,
        SCS_CONVERT
    } scs_state_t;

endpackage

// [verilog/scs_conv_clk_div.sv]
// Fixed divide-by-16 enable generator for the conversion clock.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module scs_conv_clk_div (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    // Conversion clock enable
    output logic tick
);

    logic [3:0] div_cnt;

    // Free count, realigned on restart
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 4'h0;
        end else if (restart) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1; // [RULE7]
        end
    end

    // One pulse every 16 system clocks
    assign tick = !restart && (div_cnt == scs_pkg::SCS_DIV_LAST); // [RULE7]

endmodule // scs_conv_clk_div

`default_nettype wire

// [verilog/scs_sar_core.sv]
// Successive-approximation register, one bit decided per step.
// Assumes comp_hi is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module scs_sar_core (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic comp_hi,
    // Trial code
    output logic [9:0] code
);

    logic [9:0] mask;

    // Trial bit pointer walks from MSB to LSB
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask <= 10'h000;
        end else if (load) begin
            mask <= scs_pkg::SCS_RES_MSB;
        end else if (step) begin
            mask <= mask >> 1;
        end
    end

    // Each bit keeps or drops its trial, next bit gets its trial
    genvar i;
    generate
        for (i = 0; i < scs_pkg::SCS_RES_W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    code[i] <= 1'b0;
                end else if (load) begin
                    code[i] <= (i == scs_pkg::SCS_RES_W - 1); // [RULE1]
                end else if (step && mask[i]) begin
                    code[i] <= comp_hi; // [RULE16]
                end else if (step && (i < scs_pkg::SCS_RES_W - 1) && mask[(i + 1) % 10]) begin
                    code[i] <= 1'b1; // [RULE1]
                end
            end
        end
    endgenerate

endmodule // scs_sar_core

`default_nettype wire

// [verilog/scs_sequencer.sv]
// Sequencer for an eight-channel 10-bit SAR converter: register port,
// sample/settle/convert phases, result store and completion request.
// Assumes an analog front end driven by analog_ctrl and a comparator
// output comp_hi_pin that arrives asynchronously.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog front end
    input wire logic comp_hi_pin,
    output scs_pkg::scs_analog_t analog_ctrl,
    // Interrupt request towards the interrupt controller
    input wire logic irq_ack,
    output logic irq_req
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    scs_pkg::scs_ctrl_t ctrl;
    scs_pkg::scs_state_t state;
    scs_pkg::scs_state_t next_state;
    logic [7:0] sample_time;
    logic [7:0] settle_time;
    logic [9:0] result;
    logic [7:0] phase_cnt;
    logic [3:0] tick_cnt;
    logic comp_meta;
    logic comp_sync;
    logic conv_tick;
    logic ctrl_wr;
    logic start_req;
    logic sample_end;
    logic settle_end;
    logic conv_end;
    logic sar_load;
    logic sar_step;
    logic [9:0] sar_code;
    logic busy;

    // ----------------------------------------------------------------
    // Comparator synchroniser
    // ----------------------------------------------------------------

    // Two flops before the SAR sees the comparator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comp_hi_pin;
            comp_sync <= comp_meta;
        end
    end

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------

    // Control write and start request
    assign ctrl_wr = reg_wr && (reg_addr == scs_pkg::SCS_ADDR_CTRL);
    assign start_req = ctrl_wr && reg_wdata[7] && reg_wdata[4]; // [RULE10] [RULE19]

    // Control bits below start; reserved bits hold what software wrote
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= scs_pkg::SCS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl.rsvd6 <= reg_wdata[6]; // [RULE17]
            ctrl.reference_select <= reg_wdata[5]; // [RULE15]
            ctrl.converter_enable <= reg_wdata[4]; // [RULE19]
            ctrl.rsvd3 <= reg_wdata[3]; // [RULE17]
            ctrl.channel_select <= reg_wdata[2:0]; // [RULE2]
        end
    end

    // Phase length registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_time <= scs_pkg::SCS_SAMPLE_RESET;
            settle_time <= scs_pkg::SCS_SETTLE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == scs_pkg::SCS_ADDR_SAMPLE) begin
                sample_time <= reg_wdata; // [RULE8]
            end
            if (reg_addr == scs_pkg::SCS_ADDR_SETTLE) begin
                settle_time <= reg_wdata; // [RULE9]
            end
        end
    end

    // ----------------------------------------------------------------
    // Phase sequencer
    // ----------------------------------------------------------------

    // Phase ends; a zero count still gives one cycle
    assign sample_end = (state == scs_pkg::SCS_SAMPLE) && (phase_cnt >= sample_time); // [RULE8]
    assign settle_end = (state == scs_pkg::SCS_SETTLE) && (phase_cnt >= settle_time); // [RULE9]
    assign conv_end = (state == scs_pkg::SCS_CONVERT) && conv_tick
        && (tick_cnt == scs_pkg::SCS_CONV_TICKS_LAST); // [RULE6]
    assign busy = (state != scs_pkg::SCS_IDLE);

    // Next phase; a new start always wins and restarts sampling
    always_comb begin
        next_state = state;
        case (state)
            scs_pkg::SCS_IDLE: begin
                next_state = scs_pkg::SCS_IDLE;
            end
            scs_pkg::SCS_SAMPLE: begin
                if (sample_end) begin
                    next_state = scs_pkg::SCS_SETTLE; // [RULE5]
                end
            end
            scs_pkg::SCS_SETTLE: begin
                if (settle_end) begin
                    next_state = scs_pkg::SCS_CONVERT; // [RULE5]
                end
            end
            scs_pkg::SCS_CONVERT: begin
                if (conv_end) begin
                    next_state = scs_pkg::SCS_IDLE; // [RULE18]
                end
            end
            default: begin
                next_state = scs_pkg::SCS_IDLE;
            end
        endcase
        if (start_req) begin
            next_state = scs_pkg::SCS_SAMPLE; // [RULE11]
        end else if (ctrl_wr && !reg_wdata[4]) begin
            next_state = scs_pkg::SCS_IDLE; // [RULE19]
        end
    end

    // Phase register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= scs_pkg::SCS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycle count within sampling and settling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_cnt <= 8'h00;
        end else if (start_req || sample_end || settle_end) begin
            phase_cnt <= 8'h01; // [RULE11]
        end else if (phase_cnt != 8'hFF) begin
            phase_cnt <= phase_cnt + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Conversion clock and SAR
    // ----------------------------------------------------------------

    // Divider realigned as conversion begins
    scs_conv_clk_div u_div (
        .clk(clk),
        .arst_n(arst_n),
        .restart(settle_end),
        .tick(conv_tick)
    );

    // Conversion clock cycles elapsed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= 4'h0;
        end else if (settle_end) begin
            tick_cnt <= 4'h0;
        end else if ((state == scs_pkg::SCS_CONVERT) && conv_tick) begin
            tick_cnt <= tick_cnt + 4'h1; // [RULE6]
        end
    end

    // First ten conversion clocks decide one bit each
    assign sar_load = settle_end && !start_req;
    assign sar_step = (state == scs_pkg::SCS_CONVERT) && conv_tick
        && (tick_cnt < scs_pkg::SCS_SAR_TICKS);

    scs_sar_core u_sar (
        .clk(clk),
        .arst_n(arst_n),
        .load(sar_load),
        .step(sar_step),
        .comp_hi(comp_sync),
        .code(sar_code)
    );

    // ----------------------------------------------------------------
    // Result and completion request
    // ----------------------------------------------------------------

    // Result stored on the last conversion clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result <= 10'h000;
        end else if (conv_end && !start_req) begin
            result <= sar_code; // [RULE4] [RULE1]
        end
    end

    // Sticky request; setting wins over acknowledge, enable does not clear it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_req <= 1'b0;
        end else if (conv_end && !start_req) begin
            irq_req <= 1'b1; // [RULE13]
        end else if (irq_ack) begin
            irq_req <= 1'b0; // [RULE14]
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------

    // Read data one cycle after the strobe, zero for unmapped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                scs_pkg::SCS_ADDR_CTRL: begin
                    reg_rdata <= {busy, ctrl.rsvd6, ctrl.reference_select,
                        ctrl.converter_enable, ctrl.rsvd3, ctrl.channel_select}; // [RULE12]
                end
                scs_pkg::SCS_ADDR_DATA_HI: begin
                    reg_rdata <= result[9:2]; // [RULE4]
                end
                scs_pkg::SCS_ADDR_DATA_LO: begin
                    reg_rdata <= {6'h00, result[1:0]}; // [RULE4]
                end
                scs_pkg::SCS_ADDR_SAMPLE: begin
                    reg_rdata <= sample_time;
                end
                scs_pkg::SCS_ADDR_SETTLE: begin
                    reg_rdata <= settle_time;
                end
                scs_pkg::SCS_ADDR_STATUS: begin
                    reg_rdata <= {5'h00, irq_req, 2'(state)};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Analog front-end controls
    // ----------------------------------------------------------------

    // Registered controls toward the mux, buffer, sample-hold and DAC
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.channel_select <= ctrl.channel_select; // [RULE2] [RULE3]
            analog_ctrl.reference_buffer_en <= ctrl.reference_select; // [RULE15]
            analog_ctrl.sample <= (next_state == scs_pkg::SCS_SAMPLE); // [RULE5]
            analog_ctrl.hold <= (next_state == scs_pkg::SCS_SETTLE)
                || (next_state == scs_pkg::SCS_CONVERT); // [RULE5]
            analog_ctrl.dac_code <= sar_code;
        end
    end

endmodule // scs_sequencer

`default_nettype wire

// [testbench/scs_sequencer_props.sv]
// Concurrent checks on the ports of the converter sequencer.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer_props (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Analog front end and interrupt
    input wire logic comp_hi_pin,
    input wire scs_pkg::scs_analog_t analog_ctrl,
    input wire logic irq_ack,
    input wire logic irq_req
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic ctrl_wr;
    logic start_wr;
    logic busy;
    // Decode control writes and the busy phases
    assign ctrl_wr = reg_wr && (reg_addr == scs_pkg::SCS_ADDR_CTRL);
    assign start_wr = ctrl_wr && reg_wdata[7] && reg_wdata[4];
    assign busy = analog_ctrl.sample || analog_ctrl.hold;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    start_samples_a: assert property (start_wr |=> analog_ctrl.sample)
        else $error("start write did not begin sampling");
    chan_select_a: assert property (start_wr |-> ##2
        (analog_ctrl.channel_select == $past(reg_wdata[2:0], 2)))
        else $error("channel select does not follow the start write");
    ref_select_a: assert property (start_wr |-> ##2
        (analog_ctrl.reference_buffer_en == $past(reg_wdata[5], 2)))
        else $error("reference buffer enable does not follow bit 5");
    disable_stops_a: assert property (ctrl_wr && !reg_wdata[4] |-> ##2 !busy)
        else $error("sequence kept running while disabled");
    hold_after_sample_a: assert property ($rose(analog_ctrl.hold) |-> $past(analog_ctrl.sample))
        else $error("hold began without a sampling phase before it");
    irq_at_end_a: assert property ($rose(irq_req) |-> $fell(analog_ctrl.hold))
        else $error("completion request not aligned with end of conversion");
    irq_sticky_a: assert property (irq_req && !irq_ack |=> irq_req)
        else $error("completion request dropped without a clear");
    busy_read_a: assert property (reg_rd && reg_addr == scs_pkg::SCS_ADDR_CTRL |=>
        reg_rdata[7] == $past(busy))
        else $error("start bit read does not show busy");
    unmapped_zero_a: assert property (reg_rd && reg_addr > scs_pkg::SCS_ADDR_STATUS |=>
        reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");

    // Main scenarios reached
    cover property ($rose(irq_req));
    cover property (start_wr && busy);
    cover property (irq_req && ctrl_wr && !reg_wdata[4]);
endmodule // scs_sequencer_props

bind scs_sequencer scs_sequencer_props chk (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .comp_hi_pin(comp_hi_pin),
    .analog_ctrl(analog_ctrl),
    .irq_ack(irq_ack),
    .irq_req(irq_req)
);
`default_nettype wire

// [testbench/tb_scs_sequencer.sv]
// Self-checking bench for the converter sequencer.
// Assumes the comparator is modelled here from per-channel input codes.
`timescale 1ns/1ps
`default_nettype none

module tb_scs_sequencer;
    logic clk;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic comp_hi_pin;
    scs_pkg::scs_analog_t analog_ctrl;
    logic irq_ack;
    logic irq_req;
    logic [9:0] ain [8];
    logic [9:0] exp_q [$];
    logic [31:0] seed;
    int fails;
    int tests_run;
    int samp_cyc;
    int sett_cyc;

    scs_sequencer dut (
        .clk(clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .comp_hi_pin(comp_hi_pin),
        .analog_ctrl(analog_ctrl),
        .irq_ack(irq_ack),
        .irq_req(irq_req)
    );

    // ----------------------------------------
    // Clock and comparator
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Input sits half a step above its code, so the result equals the code
    always @(posedge clk) begin
        comp_hi_pin <= ({analog_ctrl.dac_code, 1'b0} < {ain[analog_ctrl.channel_select], 1'b1});
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Bounded wait for completion; n is cycles since the start edge t0
    task automatic wait_irq(input realtime t0, output int n);
        n = -1;
        for (int i = 0; i < 1000; i++) begin
            @(negedge clk);
            if (irq_req === 1'b1) begin
                n = int'(($realtime - t0 - 5.0) / 10.0);
                break;
            end
        end
        if (n < 0) begin
            fails++;
            close_out();
        end
    endtask

    task automatic ack();
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        @(negedge clk);
        chk(irq_req, 1'b0);
    endtask

    // One full conversion with timing, result and status checks
    task automatic convert(input logic [2:0] ch, input logic ref_sel);
        realtime t0;
        int n;
        logic [7:0] d;
        logic [7:0] hi;
        wr(scs_pkg::SCS_ADDR_CTRL, {2'b10, ref_sel, 2'b10, ch});
        t0 = $realtime;
        exp_q.push_back(ain[ch]);
        rd(scs_pkg::SCS_ADDR_CTRL, d);
        chk(d, {2'b10, ref_sel, 2'b10, ch});
        chk(analog_ctrl.channel_select, ch);
        chk(analog_ctrl.reference_buffer_en, ref_sel);
        wait_irq(t0, n);
        chk(16'(n), 16'(samp_cyc + sett_cyc + 16 * 13));
        rd(scs_pkg::SCS_ADDR_DATA_HI, hi);
        rd(scs_pkg::SCS_ADDR_DATA_LO, d);
        chk({hi, d[1:0]}, exp_q.pop_front());
        rd(scs_pkg::SCS_ADDR_CTRL, d);
        chk(d[7], 1'b0);
        ack();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        int n;
        realtime t0;
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        irq_ack = 1'b0;
        fails = 0;
        tests_run = 0;
        samp_cyc = 100;
        sett_cyc = 50;
        seed = 32'hD0E2;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            ain[i] = seed[9:0];
        end
        ain[0] = 10'h000;
        ain[7] = 10'h3FF;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values and an unmapped address
        rd(scs_pkg::SCS_ADDR_CTRL, d);
        chk(d, 8'h00);
        rd(scs_pkg::SCS_ADDR_SAMPLE, d);
        chk(d, 8'h64);
        rd(scs_pkg::SCS_ADDR_SETTLE, d);
        chk(d, 8'h32);
        rd(8'h09, d);
        chk(d, 8'h00);
        // Control fields stored without starting
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h25);
        rd(scs_pkg::SCS_ADDR_CTRL, d);
        chk(d, 8'h25);
        // Every channel code, limits included
        for (int c = 0; c < 8; c++) begin
            convert(3'(c), c[0]);
        end
        // Programmed phase lengths
        wr(scs_pkg::SCS_ADDR_SAMPLE, 8'h6E);
        wr(scs_pkg::SCS_ADDR_SETTLE, 8'h3C);
        samp_cyc = 110;
        sett_cyc = 60;
        rd(scs_pkg::SCS_ADDR_SETTLE, d);
        chk(d, 8'h3C);
        seed = xs(seed);
        ain[3] = seed[9:0];
        convert(3'd3, 1'b0);
        // Restart in mid-conversion runs the full sequence again
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h92);
        repeat (200) @(posedge clk);
        convert(3'd6, 1'b1);
        // Disable during settling gives no result
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h91);
        repeat (150) @(posedge clk);
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h01);
        repeat (450) @(posedge clk);
        @(negedge clk);
        chk(irq_req, 1'b0);
        // Pending request survives disable
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h94);
        t0 = $realtime;
        wait_irq(t0, n);
        wr(scs_pkg::SCS_ADDR_CTRL, 8'h04);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(irq_req, 1'b1);
        rd(scs_pkg::SCS_ADDR_STATUS, d);
        chk(d, 8'h04);
        ack();
        close_out();
    end
endmodule // tb_scs_sequencer
`default_nettype wire
